// ### hw/pilot_pkg.sv
// Shared constants and types for the stereo pilot qualifier
package pilot_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10000000;
  localparam int PILOT_HZ = 25;
  localparam int PERIOD_CYCLES = CLK_HZ / PILOT_HZ;
  localparam int PCNT_W = 19;
  // ----------------------------------------------------------------
  // Counts
  // ----------------------------------------------------------------
  localparam logic [5:0] SHORT_COUNT = 6'h07;
  localparam logic [5:0] LONG_COUNT = 6'h25;
  localparam logic [5:0] NO_PILOT_COUNT = 6'h07;
  localparam logic [5:0] CNT_RESET = 6'h00;
  localparam logic [5:0] CNT_MAX = 6'h3F;
  typedef enum logic [1:0] {ST_MUTE, ST_ACQ, ST_STEREO} qual_state_t;
endpackage

// ### hw/pilot_if.sv
// Per-period pilot sampling results passed to the qualifier core
`timescale 1ns/1ns
interface pilot_if;
  logic tick;
  logic pilot_seen;
  modport src (output tick, output pilot_seen);
  modport dst (input tick, input pilot_seen);
endinterface

// ### hw/pilot_sampler.sv
// Samples pilot edges once per nominal pilot period
`timescale 1ns/1ns
module pilot_sampler #(
  parameter int PERIOD = pilot_pkg::PERIOD_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic restart,
  input wire logic pilot_edge,
  pilot_if.src smp
);
  import pilot_pkg::*;
  logic [PCNT_W-1:0] div_reg, div_next;
  logic seen_reg, seen_next;
  logic tick_reg, tick_next;
  logic pseen_reg, pseen_next;

  always_comb begin
    div_next = div_reg + 1'b1;
    seen_next = seen_reg | pilot_edge;
    tick_next = 1'b0;
    pseen_next = pseen_reg;
    if (restart) begin
      div_next = '0;
      seen_next = 1'b0;
    end else if (div_reg == PCNT_W'(PERIOD - 1)) begin
      // One verdict per period
      div_next = '0;
      seen_next = 1'b0;
      tick_next = 1'b1;
      pseen_next = seen_reg | pilot_edge;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      div_reg <= '0;
      seen_reg <= 1'b0;
      tick_reg <= 1'b0;
      pseen_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      seen_reg <= seen_next;
      tick_reg <= tick_next;
      pseen_reg <= pseen_next;
    end
  end

  assign smp.tick = tick_reg;
  assign smp.pilot_seen = pseen_reg;
endmodule

// ### hw/input_sync.sv
// Two-stage synchroniser for a bundle of pin levels
`timescale 1ns/1ns
module input_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_reg, s2_reg;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
    end
  end

  assign q = s2_reg;
endmodule

// ### hw/stereo_pilot_qualifier.sv
// Mono/stereo decision logic driven by a 25 Hz pilot count
`timescale 1ns/1ns
module stereo_pilot_qualifier #(
  // Clock cycles per pilot sampling window
  parameter int PERIOD = pilot_pkg::PERIOD_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic force_mono_n,
  input wire logic pll_lock,
  input wire logic cochannel_trip,
  input wire logic carrier_low,
  input wire logic inphase_detector_neg,
  input wire logic pilot_in,
  output logic diff_switch_en,
  output logic stereo_lamp_n,
  output logic long_mode,
  output logic [5:0] pilot_count
);
  import pilot_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [5:0] raw_pins, sync_pins;
  logic fm_n_s, lock_s, coch_s, low_s, neg_s, pilot_s;

  assign raw_pins = {force_mono_n, pll_lock, cochannel_trip, carrier_low,
                     inphase_detector_neg, pilot_in};

  input_sync #(.W(6)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .d(raw_pins),
    .q(sync_pins)
  );

  assign {fm_n_s, lock_s, coch_s, low_s, neg_s, pilot_s} = sync_pins;

  // Pilot edge detect reads only the synchronised copy
  logic pilot_d_reg;
  logic pilot_edge;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pilot_d_reg <= 1'b0;
    end else begin
      pilot_d_reg <= pilot_s;
    end
  end
  assign pilot_edge = pilot_s & ~pilot_d_reg;

  // ----------------------------------------------------------------
  // Period sampler
  // ----------------------------------------------------------------
  pilot_if smp ();
  logic restart;
  // Realign the sampling grid on release of forced mono
  assign restart = ~fm_n_s;

  pilot_sampler #(.PERIOD(PERIOD)) u_smp (
    .core_clk(core_clk),
    .rst(rst),
    .restart(restart),
    .pilot_edge(pilot_edge),
    .smp(smp)
  );

  // ----------------------------------------------------------------
  // Qualifier state
  // ----------------------------------------------------------------
  qual_state_t state_reg, state_next;
  logic long_reg, long_next;
  logic [5:0] cnt_reg, cnt_next;
  logic [2:0] miss_reg, miss_next;
  logic [2:0] early_reg, early_next;
  logic sw_reg, sw_next;
  logic lamp_n_reg, lamp_n_next;

  function automatic logic [5:0] sat_inc(input logic [5:0] v);
    sat_inc = (v == CNT_MAX) ? v : v + 6'h01;
  endfunction

  logic disturb;
  logic [5:0] target;
  logic [5:0] cnt_inc;
  // Co-channel only counts as a disturbance during acquisition
  assign disturb = ~lock_s | coch_s;
  assign target = long_reg ? LONG_COUNT : SHORT_COUNT;
  assign cnt_inc = sat_inc(cnt_reg);

  always_comb begin
    state_next = state_reg;
    long_next = long_reg;
    cnt_next = cnt_reg;
    miss_next = miss_reg;
    early_next = early_reg;
    sw_next = 1'b0;
    lamp_n_next = 1'b1;
    unique case (state_reg)
      ST_MUTE: begin
        // Held in mono, short count armed for next acquisition
        long_next = 1'b0;
        cnt_next = CNT_RESET;
        miss_next = 3'h0;
        early_next = 3'h0;
        if (fm_n_s) begin
          state_next = ST_ACQ;
        end
      end
      ST_ACQ: begin
        if (!fm_n_s) begin
          state_next = ST_MUTE;
        end else if (disturb) begin
          cnt_next = CNT_RESET;
          miss_next = 3'h0;
          if (early_reg < 3'(NO_PILOT_COUNT)) begin
            long_next = 1'b1;
          end
        end else if (smp.tick) begin
          if (early_reg < 3'(NO_PILOT_COUNT)) begin
            early_next = early_reg + 3'h1;
          end
          if (smp.pilot_seen) begin
            cnt_next = cnt_inc;
            miss_next = 3'h0;
          end else begin
            cnt_next = CNT_RESET;
            if (miss_reg == 3'(NO_PILOT_COUNT - 1)) begin
              long_next = 1'b1;
              miss_next = 3'h0;
            end else begin
              miss_next = miss_reg + 3'h1;
            end
          end
        end else if (cnt_reg >= target && !low_s) begin
          // Low carrier waits here without touching count or mode
          state_next = ST_STEREO;
          miss_next = 3'h0;
          sw_next = 1'b1;
          lamp_n_next = 1'b0;
        end
      end
      ST_STEREO: begin
        sw_next = 1'b1;
        lamp_n_next = 1'b0;
        if (!fm_n_s) begin
          state_next = ST_MUTE;
          sw_next = 1'b0;
          lamp_n_next = 1'b1;
        end else if (!lock_s || neg_s || low_s) begin
          // Co-channel input not looked at here
          state_next = ST_ACQ;
          cnt_next = CNT_RESET;
          miss_next = 3'h0;
          sw_next = 1'b0;
          lamp_n_next = 1'b1;
        end else if (smp.tick) begin
          if (smp.pilot_seen) begin
            miss_next = 3'h0;
          end else if (miss_reg == 3'(NO_PILOT_COUNT - 1)) begin
            state_next = ST_ACQ;
            cnt_next = CNT_RESET;
            miss_next = 3'h0;
            sw_next = 1'b0;
            lamp_n_next = 1'b1;
          end else begin
            miss_next = miss_reg + 3'h1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= ST_MUTE;
      long_reg <= 1'b0;
      cnt_reg <= CNT_RESET;
      miss_reg <= 3'h0;
      early_reg <= 3'h0;
      sw_reg <= 1'b0;
      lamp_n_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      long_reg <= long_next;
      cnt_reg <= cnt_next;
      miss_reg <= miss_next;
      early_reg <= early_next;
      sw_reg <= sw_next;
      lamp_n_reg <= lamp_n_next;
    end
  end

  assign diff_switch_en = sw_reg;
  assign stereo_lamp_n = lamp_n_reg;
  assign long_mode = long_reg;
  assign pilot_count = cnt_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_short_entry;
    @(posedge core_clk) disable iff (rst)
      (state_reg == ST_ACQ && state_next == ST_STEREO && !long_reg)
        |-> cnt_reg >= SHORT_COUNT;
  endproperty
  a_short_entry: assert property (p_short_entry)
    else $error("stereo entered short mode before seven counts");

  property p_long_entry;
    @(posedge core_clk) disable iff (rst)
      (state_reg == ST_ACQ && state_next == ST_STEREO && long_reg)
        |-> cnt_reg >= LONG_COUNT;
  endproperty
  a_long_entry: assert property (p_long_entry)
    else $error("stereo entered long mode before 37 counts");

  property p_mute_short;
    @(posedge core_clk) disable iff (rst)
      !fm_n_s |-> ##2 (!long_reg && !sw_reg);
  endproperty
  a_mute_short: assert property (p_mute_short)
    else $error("forced mono did not hold mono and short count");

  property p_disturb_clear;
    @(posedge core_clk) disable iff (rst)
      (state_reg == ST_ACQ && fm_n_s && disturb) |=> cnt_reg == CNT_RESET;
  endproperty
  a_disturb_clear: assert property (p_disturb_clear)
    else $error("disturbance did not clear pilot count");

  property p_low_keeps;
    @(posedge core_clk) disable iff (rst)
      (state_reg == ST_ACQ && fm_n_s && low_s && !disturb && !smp.tick)
        |=> ($stable(cnt_reg) && $stable(long_reg) && !sw_reg);
  endproperty
  a_low_keeps: assert property (p_low_keeps)
    else $error("low carrier changed counter or allowed stereo");

  property p_fast_drop;
    @(posedge core_clk) disable iff (rst)
      (state_reg == ST_STEREO && (!lock_s || neg_s || low_s))
        |=> (!sw_reg && stereo_lamp_n);
  endproperty
  a_fast_drop: assert property (p_fast_drop)
    else $error("stereo not dropped at once on lock or carrier loss");

  property p_coch_ignored;
    @(posedge core_clk) disable iff (rst)
      (state_reg == ST_STEREO && fm_n_s && lock_s && !neg_s && !low_s
        && !smp.tick) |=> state_reg == ST_STEREO;
  endproperty
  a_coch_ignored: assert property (p_coch_ignored)
    else $error("stereo left without cause");

  property p_outputs_agree;
    @(posedge core_clk) disable iff (rst)
      sw_reg == !lamp_n_reg && sw_reg == (state_reg == ST_STEREO);
  endproperty
  a_outputs_agree: assert property (p_outputs_agree)
    else $error("switch and lamp disagree with state");

  property p_coch_block;
    @(posedge core_clk) disable iff (rst)
      (state_reg == ST_ACQ && coch_s) |=> state_reg != ST_STEREO;
  endproperty
  a_coch_block: assert property (p_coch_block)
    else $error("stereo entered during co-channel trip");

  property p_empty_long;
    @(posedge core_clk) disable iff (rst)
      (state_reg == ST_ACQ && fm_n_s && !disturb && smp.tick
        && !smp.pilot_seen && miss_reg == 3'(NO_PILOT_COUNT - 1))
        |=> long_reg;
  endproperty
  a_empty_long: assert property (p_empty_long)
    else $error("seven empty periods did not select long count");

  property p_early_long;
    @(posedge core_clk) disable iff (rst)
      (state_reg == ST_ACQ && fm_n_s && disturb
        && early_reg < 3'(NO_PILOT_COUNT)) |=> long_reg;
  endproperty
  a_early_long: assert property (p_early_long)
    else $error("early disturbance did not select long count");

  property p_silent_drop;
    @(posedge core_clk) disable iff (rst)
      (state_reg == ST_STEREO && fm_n_s && lock_s && !neg_s && !low_s
        && smp.tick && !smp.pilot_seen
        && miss_reg == 3'(NO_PILOT_COUNT - 1)) |=> !sw_reg;
  endproperty
  a_silent_drop: assert property (p_silent_drop)
    else $error("stereo kept after seven empty pilot periods");

  property p_neg_drop;
    @(posedge core_clk) disable iff (rst)
      (state_reg == ST_STEREO && neg_s) |=> (!sw_reg && stereo_lamp_n);
  endproperty
  a_neg_drop: assert property (p_neg_drop)
    else $error("in-phase excursion did not force mono");

  c_stereo: cover property (@(posedge core_clk) disable iff (rst)
    state_reg == ST_ACQ ##1 state_reg == ST_STEREO);
  c_long_stereo: cover property (@(posedge core_clk) disable iff (rst)
    long_reg && state_reg == ST_STEREO);
  c_drop: cover property (@(posedge core_clk) disable iff (rst)
    state_reg == ST_STEREO ##1 state_reg == ST_ACQ);
endmodule

// ### test/pilot_source.sv
// Behavioural tuner side: squared 25 Hz pilot from the IF strip
`timescale 1ns/1ns
module pilot_source #(
  parameter int P = pilot_pkg::PERIOD_CYCLES
) (
  input wire logic core_clk,
  input wire logic enable,
  output logic pilot_in
);
  // ----------------------------------------------------------------
  // Pilot phase
  // ----------------------------------------------------------------
  // Phase restarts on enable so each sample window holds one edge
  int unsigned ph = 0;
  always @(posedge core_clk) begin
    if (!enable) begin
      ph <= 0;
    end else begin
      ph <= (ph == P - 1) ? 0 : ph + 1;
    end
  end
  // Filter output sits low while no pilot is carried
  assign pilot_in = enable && (ph >= P / 4) && (ph < 3 * (P / 4));
endmodule

// ### test/testbench.sv
// Self-checking bench for the stereo pilot qualifier
`timescale 1ns/1ns
module testbench;
  import pilot_pkg::*;
  // Shortened pilot period keeps the run to a few tens of thousands cycles
  localparam int W = 400;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic force_mono_n = 1'b0;
  logic pll_lock = 1'b1;
  logic cochannel_trip = 1'b0;
  logic carrier_low = 1'b0;
  logic inphase_detector_neg = 1'b0;
  logic pilot_en = 1'b0;
  logic pilot_in;
  logic diff_switch_en;
  logic stereo_lamp_n;
  logic long_mode;
  logic [5:0] pilot_count;
  int fails = 0;
  int cmp_count = 0;

  always #50 core_clk = ~core_clk;

  stereo_pilot_qualifier #(.PERIOD(W)) dut (
    .core_clk(core_clk),
    .rst(rst),
    .force_mono_n(force_mono_n),
    .pll_lock(pll_lock),
    .cochannel_trip(cochannel_trip),
    .carrier_low(carrier_low),
    .inphase_detector_neg(inphase_detector_neg),
    .pilot_in(pilot_in),
    .diff_switch_en(diff_switch_en),
    .stereo_lamp_n(stereo_lamp_n),
    .long_mode(long_mode),
    .pilot_count(pilot_count)
  );

  pilot_source #(.P(W)) tuner (
    .core_clk(core_clk),
    .enable(pilot_en),
    .pilot_in(pilot_in)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #10;
  endtask

  task automatic chk(input string what, input logic [5:0] exp,
                     input logic [5:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic outs(input logic sw, input logic lm);
    chk("diff_switch_en", {5'h00, sw}, {5'h00, diff_switch_en});
    chk("stereo_lamp_n", {5'h00, ~sw}, {5'h00, stereo_lamp_n});
    chk("long_mode", {5'h00, lm}, {5'h00, long_mode});
  endtask

  task automatic wait_sw(input logic exp, input int max);
    int i;
    for (i = 0; i < max && diff_switch_en !== exp; i++) step(1);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    step(16);
    rst = 1'b0;
    outs(1'b0, 1'b0);
    chk("pilot_count", 6'h00, pilot_count);
    // Disturbances while muted must not pick long mode
    pll_lock = 1'b0;
    cochannel_trip = 1'b1;
    step(10);
    pll_lock = 1'b1;
    cochannel_trip = 1'b0;
    step(20);
    outs(1'b0, 1'b0);
    chk("pilot_count", 6'h00, pilot_count);
    // Short acquisition held off by a weak carrier
    carrier_low = 1'b1;
    force_mono_n = 1'b1;
    pilot_en = 1'b1;
    step(7 * W + W / 2);
    outs(1'b0, 1'b0);
    chk("pilot_count", SHORT_COUNT, pilot_count);
    carrier_low = 1'b0;
    wait_sw(1'b1, 10);
    outs(1'b1, 1'b0);
    // Beat note ignored once in stereo
    cochannel_trip = 1'b1;
    step(20);
    outs(1'b1, 1'b0);
    cochannel_trip = 1'b0;
    // Lock loss drops stereo without counting
    pll_lock = 1'b0;
    step(4);
    outs(1'b0, 1'b0);
    chk("pilot_count", CNT_RESET, pilot_count);
    pll_lock = 1'b1;
    // Reacquire, then drop on an in-phase excursion
    wait_sw(1'b1, 8 * W);
    outs(1'b1, 1'b0);
    inphase_detector_neg = 1'b1;
    step(4);
    outs(1'b0, 1'b0);
    inphase_detector_neg = 1'b0;
    // Reacquire, then drop on a weak carrier
    wait_sw(1'b1, 8 * W);
    outs(1'b1, 1'b0);
    carrier_low = 1'b1;
    step(4);
    outs(1'b0, 1'b0);
    chk("pilot_count", CNT_RESET, pilot_count);
    carrier_low = 1'b0;
    // Retune, then beat note two periods into acquisition
    force_mono_n = 1'b0;
    pilot_en = 1'b0;
    step(20);
    outs(1'b0, 1'b0);
    force_mono_n = 1'b1;
    pilot_en = 1'b1;
    step(2 * W + W / 2);
    chk("pilot_count", 6'h02, pilot_count);
    cochannel_trip = 1'b1;
    step(5);
    cochannel_trip = 1'b0;
    step(5);
    outs(1'b0, 1'b1);
    chk("pilot_count", CNT_RESET, pilot_count);
    // Retune to a station carrying no pilot
    force_mono_n = 1'b0;
    pilot_en = 1'b0;
    step(20);
    outs(1'b0, 1'b0);
    force_mono_n = 1'b1;
    step(6 * W + W / 2);
    outs(1'b0, 1'b0);
    step(W);
    outs(1'b0, 1'b1);
    // Pilot returns while on the long count
    pilot_en = 1'b1;
    step(36 * W);
    outs(1'b0, 1'b1);
    wait_sw(1'b1, 2 * W);
    outs(1'b1, 1'b1);
    chk("pilot_count", LONG_COUNT, pilot_count);
    // Pilot lost while in stereo
    pilot_en = 1'b0;
    step(6 * W);
    outs(1'b1, 1'b1);
    wait_sw(1'b0, 3 * W);
    outs(1'b0, 1'b1);
    chk("pilot_count", CNT_RESET, pilot_count);
    summarize();
  end

  // Whole sequence spans about seventy-five pilot periods
  initial begin
    repeat (90 * W) @(posedge core_clk);
    fails++;
    summarize();
  end
endmodule
